//--- hdl/ssio_params.svh
/*
   Constants of the synchronous SRAM I/O control slice: register offsets,
   field positions, reset values and widths.
   Assumes it is included by bare name; the guard allows repeated inclusion.
*/
`ifndef SSIO_PARAMS_SVH
`define SSIO_PARAMS_SVH

// Register byte offsets
`define SSIO_OFS_CTRL 8'h00
`define SSIO_OFS_STATUS 8'h04
`define SSIO_OFS_CAPT_DATA 8'h08
`define SSIO_OFS_CAPT_PAR 8'h0c

// Field positions and reset values
`define SSIO_CTRL_CAPT_EN 0
`define SSIO_CTRL_RST 1'b0
`define SSIO_STAT_ILV 0
`define SSIO_STAT_CAPT_VLD 1
`define SSIO_STAT_CAPT_RDY 2
`define SSIO_STAT_OP_LO 3
`define SSIO_STRAP_RST 1'b1
`define SSIO_BW_RST 4'hf

// Widths and depths
`define SSIO_DATA_W 32
`define SSIO_PAR_W 4
`define SSIO_WORD_W 36
`define SSIO_ADDR_W 4
`define SSIO_MEM_DEPTH 16
`define SSIO_FIFO_DEPTH 2
`define SSIO_HSIZE_WORD 3'b010

`endif

//--- hdl/ssio_pkg.sv
/*
   Types shared by the SRAM I/O control slice.
   Assumes ssio_params.svh is on the include path.
*/
`include "ssio_params.svh"

package ssio_pkg;
   // Data-phase operation of the memory bus
   typedef enum logic [1:0] {
      ST_DESEL = 2'b00,
      ST_READ = 2'b01,
      ST_WRITE = 2'b10
   } ssio_op_e;

   // One memory word: parity lanes above the data lanes
   typedef logic [`SSIO_WORD_W-1:0] ssio_word_t;
endpackage

//--- hdl/ssio_fifo_if.sv
/*
   Valid/ready carrier between the I/O slice and its capture buffer.
   Assumes both sides run on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none

interface ssio_fifo_if;
   import ssio_pkg::*;
   logic push_valid;
   logic push_ready;
   ssio_word_t push_data;
   logic pop_valid;
   logic pop_ready;
   ssio_word_t pop_data;

   modport fifo (
      input push_valid, push_data, pop_ready,
      output push_ready, pop_valid, pop_data
   );
   modport user (
      output push_valid, push_data, pop_ready,
      input push_ready, pop_valid, pop_data
   );
endinterface

`default_nettype wire

//--- hdl/ssio_fifo.sv
/*
   Two-entry buffer for captured write words.
   Assumes a synchronous active-low reset and one clock.
*/
`timescale 1ns/10ps
`default_nettype none

module ssio_fifo
   import ssio_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Buffer ports
   ssio_fifo_if.fifo fq
);
   ssio_word_t mem_q [`SSIO_FIFO_DEPTH];
   logic wr_ptr_q;
   logic rd_ptr_q;
   logic [1:0] cnt_q;
   logic do_push;
   logic do_pop;

   // Handshake decode
   assign fq.push_ready = (cnt_q != 2'h2);
   assign fq.pop_valid = (cnt_q != 2'h0);
   assign fq.pop_data = mem_q[rd_ptr_q];
   assign do_push = fq.push_valid & fq.push_ready;
   assign do_pop = fq.pop_ready & fq.pop_valid;

   // Storage
   always_ff @(posedge clk) begin
      if (do_push) begin
         mem_q[wr_ptr_q] <= fq.push_data;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         wr_ptr_q <= wr_ptr_q ^ do_push;
         rd_ptr_q <= rd_ptr_q ^ do_pop;
         cnt_q <= cnt_q + {1'b0, do_push} - {1'b0, do_pop};
      end
   end
endmodule

`default_nettype wire

//--- hdl/ssio_top.sv
/*
   Pin-level control slice of a pipelined synchronous burst SRAM with
   a small word array, lane direction control, burst sequencing and an
   AHB-Lite register port with a capture buffer for written words.
   Assumes one clock, synchronous inputs and a single AHB-Lite master.
*/
`timescale 1ns/10ps
`default_nettype none

module ssio_top
   import ssio_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // Memory bus control
   input wire logic clock_gate_n,
   input wire logic chip_sel_n,
   input wire logic write_en_n,
   input wire logic adv_ld,
   input wire logic [`SSIO_ADDR_W-1:0] addr,
   input wire logic [`SSIO_PAR_W-1:0] byte_write_sel_n,
   input wire logic out_drive_n,
   input wire logic burst_mode_strap,
   // Data lanes
   input wire logic [`SSIO_DATA_W-1:0] dq_i,
   output logic [`SSIO_DATA_W-1:0] dq_o,
   output logic dq_oe,
   // Parity lanes
   input wire logic [`SSIO_PAR_W-1:0] parity_io_lanes_i,
   output logic [`SSIO_PAR_W-1:0] parity_io_lanes_o,
   output logic parity_io_lanes_oe
);
   // Burst address step: linear add or interleaved XOR
   function automatic logic [1:0] burst_addr(input logic [1:0] start, input logic [1:0] beat,
                                             input logic ilv);
      return ilv ? (start ^ beat) : (start + beat);
   endfunction

   ssio_fifo_if fq ();

   ssio_word_t mem_q [`SSIO_MEM_DEPTH];
   ssio_op_e op_q;
   ssio_op_e op_d;
   logic [`SSIO_ADDR_W-1:0] addr_q;
   logic [`SSIO_ADDR_W-1:0] addr_d;
   logic [1:0] start_q;
   logic [1:0] start_d;
   logic [1:0] beat_q;
   logic [1:0] beat_d;
   logic [1:0] beat_inc;
   logic [`SSIO_PAR_W-1:0] bw_q;
   logic [`SSIO_PAR_W-1:0] bw_d;
   logic [`SSIO_DATA_W-1:0] dq_o_q;
   logic [`SSIO_DATA_W-1:0] dq_o_d;
   logic dq_oe_q;
   logic dq_oe_d;
   logic [`SSIO_PAR_W-1:0] par_o_q;
   logic [`SSIO_PAR_W-1:0] par_o_d;
   logic par_oe_q;
   logic interleave_q;
   logic strap_done_q;
   logic cap_en_q;
   logic wr_pend_q;
   logic [7:0] wr_ofs_q;
   logic [31:0] hrdata_q;
   logic [31:0] hrdata_d;
   logic [31:0] rd_mux;
   ssio_word_t rd_word;
   logic en;
   logic stall;
   logic wr_phase;
   logic cap_push;
   logic new_cmd;
   logic burst_go;
   logic emerge_d;
   logic drive_d;
   logic ap;
   logic ap_rd;
   logic [7:0] ofs;

   // Capture buffer
   ssio_fifo ssio_fifo_i (
      .clk(clk),
      .rst_n(rst_n),
      .fq(fq.fifo)
   );

   // Outputs straight from flops or tied constants
   assign dq_o = dq_o_q;
   assign dq_oe = dq_oe_q;
   assign parity_io_lanes_o = par_o_q;
   assign parity_io_lanes_oe = par_oe_q;
   assign hrdata = hrdata_q;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Edge qualification; a full buffer stretches a write data phase
   assign wr_phase = (op_q == ST_WRITE);
   assign cap_push = cap_en_q & wr_phase & ~clock_gate_n;
   assign stall = cap_push & ~fq.push_ready;
   assign en = ~clock_gate_n & ~stall;
   assign fq.push_valid = cap_push;
   assign fq.push_data = {parity_io_lanes_i, dq_i};

   // Command decode for the next data phase
   assign new_cmd = ~chip_sel_n & ~adv_ld;
   assign burst_go = adv_ld & (op_q != ST_DESEL);
   assign beat_inc = beat_q + 2'h1;
   assign op_d = !en ? op_q :
                 new_cmd ? (write_en_n ? ST_READ : ST_WRITE) :
                 burst_go ? op_q : ST_DESEL;
   assign start_d = (en & new_cmd) ? addr[1:0] : start_q;
   assign beat_d = (en & new_cmd) ? 2'h0 : (en & burst_go) ? beat_inc : beat_q;
   assign addr_d = (en & new_cmd) ? addr :
                   (en & burst_go) ? {addr_q[3:2], burst_addr(start_q, beat_inc, interleave_q)} :
                   addr_q;
   assign bw_d = (en & (new_cmd | burst_go)) ? byte_write_sel_n : bw_q;

   // Lane direction: read phase, not emerging, output drive low
   assign emerge_d = (op_q == ST_DESEL) & (op_d != ST_DESEL);
   assign drive_d = (op_d == ST_READ) & ~emerge_d & ~out_drive_n;
   assign rd_word = mem_q[addr_d];
   assign dq_o_d = en ? rd_word[`SSIO_DATA_W-1:0] : dq_o_q;
   assign par_o_d = en ? rd_word[`SSIO_WORD_W-1:`SSIO_DATA_W] : par_o_q;
   assign dq_oe_d = en ? drive_d : dq_oe_q;

   // Memory-bus pipeline state
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         op_q <= ST_DESEL;
         addr_q <= '0;
         start_q <= 2'h0;
         beat_q <= 2'h0;
         bw_q <= `SSIO_BW_RST;
         dq_o_q <= '0;
         dq_oe_q <= 1'b0;
         par_o_q <= '0;
         par_oe_q <= 1'b0;
      end else begin
         op_q <= op_d;
         addr_q <= addr_d;
         start_q <= start_d;
         beat_q <= beat_d;
         bw_q <= bw_d;
         dq_o_q <= dq_o_d;
         dq_oe_q <= dq_oe_d;
         par_o_q <= par_o_d;
         par_oe_q <= dq_oe_d;
      end
   end

   // Byte-gated write of data and parity lanes
   always_ff @(posedge clk) begin
      if (en && wr_phase) begin
         for (int b = 0; b < `SSIO_PAR_W; b++) begin
            if (!bw_q[b]) begin
               mem_q[addr_q][8*b +: 8] <= dq_i[8*b +: 8];
               mem_q[addr_q][`SSIO_DATA_W+b] <= parity_io_lanes_i[b];
            end
         end
      end
   end

   // Burst-order strap caught once after reset release
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         interleave_q <= `SSIO_STRAP_RST;
         strap_done_q <= 1'b0;
      end else if (!strap_done_q) begin
         interleave_q <= burst_mode_strap;
         strap_done_q <= 1'b1;
      end
   end

   // AHB-Lite address phase decode
   assign ap = hsel & htrans[1] & hready & (hsize == `SSIO_HSIZE_WORD);
   assign ap_rd = ap & ~hwrite;
   assign ofs = haddr[7:0];
   assign fq.pop_ready = ap_rd & (ofs == `SSIO_OFS_CAPT_DATA);

   // Read data selection
   assign rd_mux = (ofs == `SSIO_OFS_CTRL) ? {31'h0, cap_en_q} :
                   (ofs == `SSIO_OFS_STATUS) ? {27'h0, op_q, fq.push_ready, fq.pop_valid, interleave_q} :
                   (ofs == `SSIO_OFS_CAPT_DATA && fq.pop_valid) ? fq.pop_data[`SSIO_DATA_W-1:0] :
                   (ofs == `SSIO_OFS_CAPT_PAR && fq.pop_valid) ?
                      {28'h0, fq.pop_data[`SSIO_WORD_W-1:`SSIO_DATA_W]} :
                   32'h0;
   assign hrdata_d = ap_rd ? rd_mux : 32'h0;

   // Register port state
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_pend_q <= 1'b0;
         wr_ofs_q <= 8'h00;
         hrdata_q <= 32'h0;
         cap_en_q <= `SSIO_CTRL_RST;
      end else begin
         wr_pend_q <= ap & hwrite;
         wr_ofs_q <= ofs;
         hrdata_q <= hrdata_d;
         if (wr_pend_q && wr_ofs_q == `SSIO_OFS_CTRL) begin
            cap_en_q <= hwdata[`SSIO_CTRL_CAPT_EN];
         end
      end
   end

   // Checks on the memory-bus behaviour
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_emerge;
      (op_q == ST_DESEL) ##1 (op_q != ST_DESEL);
   endsequence

   sequence s_burst_lin;
      en && burst_go && !new_cmd && !interleave_q && strap_done_q;
   endsequence

   sequence s_burst_ilv;
      en && burst_go && !new_cmd && interleave_q && strap_done_q;
   endsequence

   chk_gate_freeze: assert property (
      clock_gate_n |=> $stable(dq_o_q) && $stable(dq_oe_q) && $stable(par_o_q))
      else $error("lane outputs moved while clock gated");

   chk_gate_hold: assert property (
      clock_gate_n ##0 (op_q != ST_DESEL) |=> (op_q == $past(op_q)) && $stable(addr_q))
      else $error("gated cycle did not hold the operation");

   chk_write_capture: assert property (
      en && wr_phase && !bw_q[0] |=> mem_q[$past(addr_q)][7:0] == $past(dq_i[7:0]))
      else $error("write data byte not captured");

   chk_read_drive: assert property (
      en && (op_d == ST_READ) |=> dq_o_q == $past(rd_word[31:0]))
      else $error("read lanes do not carry the addressed word");

   chk_oe_gate: assert property (
      en && out_drive_n |=> !dq_oe_q && !parity_io_lanes_oe)
      else $error("lanes driven while output drive high");

   chk_write_tristate: assert property (
      (op_q == ST_WRITE) || (op_q == ST_DESEL) |-> !dq_oe_q)
      else $error("lanes driven in write phase or deselected");

   chk_emerge_tri: assert property (
      s_emerge |-> !dq_oe_q)
      else $error("lanes driven on first cycle after deselect");

   chk_parity_mask: assert property (
      en && wr_phase && !bw_q[1] |=> mem_q[$past(addr_q)][33] == $past(parity_io_lanes_i[1]))
      else $error("enabled parity lane not written");

   chk_parity_follow: assert property (
      parity_io_lanes_oe == dq_oe_q)
      else $error("parity lane direction differs from data");

   chk_burst_linear: assert property (
      s_burst_lin |=> addr_q[1:0] == $past(start_q) + $past(beat_q) + 2'h1)
      else $error("linear burst step wrong");

   chk_burst_ilv: assert property (
      s_burst_ilv |=> addr_q[1:0] == ($past(start_q) ^ ($past(beat_q) + 2'h1)))
      else $error("interleaved burst step wrong");
endmodule

`default_nettype wire

//--- tb/ssio_ctl_model.sv
/*
   Far-side controller lane model: resolves the shared data and parity lanes.
   Assumes the testbench tells it when the controller drives write data.
*/
`timescale 1ns/10ps
`default_nettype none

module ssio_ctl_model (
   // Clock
   input wire logic clk,
   // Controller side
   input wire logic drv,
   input wire logic [35:0] wd,
   // Device lanes
   input wire logic [35:0] dev_o,
   input wire logic dev_oe,
   output logic [35:0] lane
);
   logic [35:0] last_q = 36'h0;

   // Wire level: device first, then controller, else a changing pattern
   assign lane = dev_oe ? dev_o : drv ? wd : ~last_q;

   // Remember the level so a released lane never repeats it
   always @(posedge clk) last_q <= lane;
endmodule

`default_nettype wire

//--- tb/sync_sram_io_control_tb.sv
/*
   Self-checking bench of the SRAM I/O slice: lanes, bursts, gating, capture.
   Assumes the lane model on the data lanes and a single AHB-Lite master.
*/
`timescale 1ns/10ps
`default_nettype none

module sync_sram_io_control_tb;
   import ssio_pkg::*;
   typedef struct {int due; logic [37:0] v;} ssio_exp_s;
   localparam logic L = 1'h0;
   localparam logic H = 1'h1;
   logic clk = L, rst_n = L, hsel = L, hwrite = L, gate_n = L, cs_n = H, we_n = H, adv = L;
   logic od_n = L, strap = H, drv = L, ahb_dp = L, odv = L, gv = L, pd;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, dq_o;
   logic [1:0] htrans = '0;
   logic [3:0] a = '0, bw = 4'hf, po, b;
   logic [35:0] wd = '0, lane, nw, pw, m [16];
   logic hreadyout, hresp, dq_oe, poe;
   int cyc = 0, n_mismatch = 0, checks = 0;
   ssio_exp_s qm[$];
   logic [31:0] qa[$];

   ssio_top ssio_top_i (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .clock_gate_n(gate_n), .chip_sel_n(cs_n), .write_en_n(we_n),
      .adv_ld(adv), .addr(a), .byte_write_sel_n(bw), .out_drive_n(od_n), .burst_mode_strap(strap),
      .dq_i(lane[31:0]), .dq_o(dq_o), .dq_oe(dq_oe), .parity_io_lanes_i(lane[35:32]),
      .parity_io_lanes_o(po), .parity_io_lanes_oe(poe));
   ssio_ctl_model ssio_ctl_model_i (.clk(clk), .drv(drv), .wd(wd), .dev_o({po, dq_o}),
      .dev_oe(dq_oe), .lane(lane));

   // Clock
   initial begin
      forever #20 clk = ~clk;
   end

   task automatic chk(string nm, logic [37:0] s, logic [37:0] e);
      checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic report_and_stop();
      if (qm.size() > 0 || qa.size() > 0) begin
         n_mismatch++;
         $display("Error pending notes expected %0d seen %0d", 0, qm.size() + qa.size());
      end
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // Result watcher: oldest note against what the lanes or hrdata show
   always @(posedge clk) begin
      if (qm.size() > 0 && qm[0].due == cyc) begin
         chk("lanes", {dq_oe, poe, dq_oe ? {po, dq_o} : 36'h0}, qm[0].v);
         void'(qm.pop_front());
      end
      if (ahb_dp && hreadyout && qa.size() > 0) chk("hrdata", {6'h0, hrdata}, {6'h0, qa.pop_front()});
      if (hreadyout) ahb_dp = hsel && htrans[1] && !hwrite;
      cyc <= cyc + 1;
   end

   task automatic rdy();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== H && n < 50);
      if (hreadyout !== H) begin
         n_mismatch++;
         report_and_stop();
      end
   endtask

   task automatic ahb(logic w, logic [7:0] ad, logic [31:0] d, logic [31:0] e);
      @(posedge clk);
      hsel <= H;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, ad};
      rdy();
      if (!w) qa.push_back(e);
      hsel <= L;
      htrans <= 2'h0;
      hwdata <= d;
      rdy();
   endtask

   // One memory-bus cycle; p and d drive the previous write's data
   task automatic mc(logic c, logic w, logic v, logic [3:0] ad, logic [3:0] bs, logic p, logic [35:0] d);
      @(posedge clk);
      cs_n <= c;
      we_n <= w;
      adv <= v;
      a <= ad;
      bw <= bs;
      drv <= p;
      wd <= d;
      od_n <= odv;
      gate_n <= gv;
   endtask

   task automatic ex(logic oe, logic [35:0] w);
      qm.push_back('{cyc + 2, oe ? {2'h3, w} : 38'h0});
   endtask

   task automatic rd(logic v, logic [3:0] ad);
      mc(L, H, v, ad, 4'hf, L, 36'h0);
   endtask

   task automatic rst(logic s);
      @(posedge clk);
      rst_n <= L;
      strap <= s;
      repeat (8) @(posedge clk);
      rst_n <= H;
      qm.delete();
   endtask

   function automatic void put(int ad, logic [35:0] w, logic [3:0] bs);
      for (int i = 0; i < 4; i++) begin
         if (!bs[i]) begin
            m[ad][8*i+:8] = w[8*i+:8];
            m[ad][32+i] = w[32+i];
         end
      end
   endfunction

   // Write a word each cycle, data one cycle behind its command
   task automatic wrs(int base, int cnt);
      for (int i = 0; i < cnt; i++) begin
         nw = {4'($urandom), $urandom};
         b = (i == 4) ? 4'ha : 4'h0;
         mc(L, L, L, 4'(base + i % 4), b, pd, pw); ex(L, 36'h0);
         put(base + i % 4, nw, b);
         pd = H;
         pw = nw;
      end
      mc(H, H, L, 4'h0, 4'hf, H, pw); ex(L, 36'h0);
      mc(H, H, L, 4'h0, 4'hf, L, 36'h0); ex(L, 36'h0);
      pd = L;
   endtask

   // Main sequence
   initial begin
      void'($urandom(48));
      pd = L;
      pw = '0;
      rst(H);
      ahb(L, 8'h04, 32'h0, 32'h5);
      ahb(L, 8'h10, 32'h0, 32'h0);
      wrs(0, 5);
      $display("test writes done");
      rd(L, 4'h1); ex(L, 36'h0);
      for (int k = 1; k < 4; k++) begin
         rd(H, 4'h1); ex(H, m[1 ^ k]);
      end
      odv = H;
      rd(L, 4'h2); ex(L, 36'h0);
      odv = L;
      rd(L, 4'h0); ex(H, m[0]);
      $display("test interleaved reads done");
      rd(L, 4'h3); ex(H, m[3]);
      gv = H;
      repeat (3) begin
         mc(L, L, L, 4'h3, 4'h0, L, 36'h0); ex(H, m[3]);
      end
      gv = L;
      rd(H, 4'h0); ex(H, m[2]);
      mc(H, H, L, 4'h0, 4'hf, L, 36'h0); ex(L, 36'h0);
      $display("test clock gate done");
      ahb(H, 8'h00, 32'h1, 32'h0);
      ahb(L, 8'h00, 32'h0, 32'h1);
      wrs(4, 2);
      ahb(L, 8'h04, 32'h0, 32'h3);
      for (int i = 4; i < 6; i++) begin
         ahb(L, 8'h0c, 32'h0, {28'h0, m[i][35:32]});
         ahb(L, 8'h08, 32'h0, m[i][31:0]);
      end
      ahb(L, 8'h04, 32'h0, 32'h5);
      $display("test capture buffer done");
      rst(L);
      ahb(L, 8'h04, 32'h0, 32'h4);
      rd(L, 4'h1); ex(L, 36'h0);
      for (int k = 1; k < 4; k++) begin
         rd(H, 4'h1); ex(H, m[(1 + k) % 4]);
      end
      mc(H, H, L, 4'h0, 4'hf, L, 36'h0);
      repeat (4) @(posedge clk);
      $display("test linear reads done");
      report_and_stop();
   end
endmodule

`default_nettype wire
